// ### rtl/can_rx_buffer_consts.vh
// Purpose: Constants for the CAN receive buffer control block
// Assumes: 8-bit register port, one 25 MHz clock
// Notes:   Message vector packs identifier, flags, length and eight data bytes
`ifndef CAN_RX_BUFFER_CONSTS_VH
`define CAN_RX_BUFFER_CONSTS_VH

// Message vector layout
`define MSG_W          99
`define MSG_SID_HI     98
`define MSG_SID_LO     88
`define MSG_EID_HI     87
`define MSG_EID_LO     70
`define MSG_EXT        69
`define MSG_RTR        68
`define MSG_DLC_HI     67
`define MSG_DLC_LO     64
`define MSG_DATA_HI    63

// Register addresses
`define ADDR_PIN_CTRL  8'h0C
`define ADDR_INT_EN    8'h2B
`define ADDR_INT_FLAG  8'h2C
`define ADDR_ERR_FLAG  8'h2D
`define ADDR_HI_BASE   8'h60
`define ADDR_LO_BASE   8'h70
`define BUF_BYTES      4'hD

// Buffer control register fields
`define CTL_MODE_HI    6
`define CTL_MODE_LO    5
`define CTL_RTR        3
`define CTL_ROLL       2
`define CTL_ROLL_COPY  1
`define MODE_FILTER    2'h0
`define MODE_ANY       2'h3

// Buffer-full pin control fields
`define PIN_LEVEL_LO   4
`define PIN_EN_LO      2
`define PIN_FN_LO      0

// Reset values and writable masks
`define RST_PIN_CTRL   8'h00
`define RST_CTRL       8'h00
`define RST_INT_EN     8'h00
`define WMASK_CTRL_HI  8'h64
`define WMASK_CTRL_LO  8'h60
`define WMASK_PIN_CTRL 8'h3F

// Start-of-frame detector states
`define SOF_IDLE       2'h0
`define SOF_WAIT       2'h1
`define SOF_HOLD       2'h2

`endif

// ### rtl/can_rx_buffer_ctrl.v
// Purpose: Receive buffer control of a CAN controller
// Assumes: Acceptance compare done outside; hits arrive with each message
// Notes:   Register port uses bit-modify writes (mask selects bits changed)
//
// Function
// - Assembly buffer stalls while both hand-off slots are full; all messages, accepted or not
// - Both receive buffers operate independently
// - Whole assembly buffer copied on acceptance
// - Load sets that buffer's full flag
// - Set full flag locks buffer; host clears
// - Enabled full flag drives interrupt low
// - High-priority filters checked before low-priority
// - Control low bits hold filter and remote
// - Rollover sends high-priority overflow to low
// - Mode 00: valid filtered, extended select honoured
// - Mode 11: accept all, even errored
// - Frame-start pulse after edge held dominant
// - Dominant ending before sample point is glitch
// - Disabled buffer-full pin is high impedance
// - Interrupt-mode pin mirrors full flag inverted
// - Output-mode pin drives its level bit
`timescale 1ns/100ps
`include "can_rx_buffer_consts.vh"

module can_rx_buffer_ctrl #(
    parameter HI_FILTERS = 2,
    parameter LO_FILTERS = 4
) (
    input  wire                    clk_in,
    input  wire                    rst_n_in,
    input  wire                    msg_valid_in,
    output reg                     msg_ready_out,
    input  wire [`MSG_W-1:0]       msg_data_in,
    input  wire                    msg_error_in,
    input  wire [HI_FILTERS-1:0]   hi_filter_hit_in,
    input  wire [LO_FILTERS-1:0]   lo_filter_hit_in,
    input  wire [HI_FILTERS+LO_FILTERS-1:0] extended_id_select_in,
    input  wire                    bus_receive_input_in,
    input  wire                    bus_idle_in,
    input  wire                    sample_point_in,
    input  wire                    sof_enable_in,
    output reg                     sof_pulse_out,
    output reg                     glitch_pulse_out,
    input  wire [7:0]              reg_addr_in,
    input  wire                    reg_wr_in,
    input  wire [7:0]              reg_wdata_in,
    input  wire [7:0]              reg_mask_in,
    input  wire                    reg_rd_in,
    output reg  [7:0]              reg_rdata_out,
    output reg                     int_n_out,
    output reg  [1:0]              buffer_full_pin_out,
    output reg  [1:0]              buffer_full_pin_oe_out
);

    localparam NF    = HI_FILTERS + LO_FILTERS;
    localparam ENT_W = `MSG_W + 1 + NF;

    // Two-entry buffer between assembly buffer and commit stage
    reg [ENT_W-1:0] fifo_mem [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       fifo_count;
    wire            fifo_push;
    wire            fifo_pop;
    wire            drain_valid;
    wire            drain_ready;
    reg             commit_hold;

    // Receive buffers and their state
    reg [`MSG_W-1:0] high_priority_rx_buffer;
    reg [`MSG_W-1:0] low_priority_rx_buffer;
    reg [7:0]        high_priority_buffer_control;
    reg [7:0]        low_priority_buffer_control;
    reg [1:0]        rx_full_flag;
    reg [1:0]        rx_interrupt_enable;
    reg [1:0]        overflow_flag;
    reg [7:0]        buffer_full_pin_control;

    // Commit decision signals
    reg [ENT_W-1:0]  head;
    reg [`MSG_W-1:0] head_msg;
    reg              head_err;
    reg [NF-1:0]     head_hit;
    reg [NF-1:0]     hit_eff;
    reg [1:0]        mode_hi;
    reg [1:0]        mode_lo;
    reg              accept_hi;
    reg              accept_lo;
    reg              load_hi;
    reg              load_lo;
    reg              discard_hi;
    reg              discard_lo;
    reg [2:0]        hit_num_hi;
    reg [2:0]        hit_num_lo;
    reg [2:0]        load_lo_hit;
    integer          i;
    integer          j;

    // Start-of-frame detector
    reg [1:0] sof_state;
    reg [1:0] next_sof_state;
    reg       bus_rx_prev;

    // Register write helpers
    wire [7:0] wd_and_m  = reg_wdata_in & reg_mask_in;
    wire [7:0] keep_m    = ~reg_mask_in;
    wire       wr_pin    = reg_wr_in && (reg_addr_in == `ADDR_PIN_CTRL);
    wire       wr_ie     = reg_wr_in && (reg_addr_in == `ADDR_INT_EN);
    wire       wr_if     = reg_wr_in && (reg_addr_in == `ADDR_INT_FLAG);
    wire       wr_ef     = reg_wr_in && (reg_addr_in == `ADDR_ERR_FLAG);
    wire       wr_ctl_hi = reg_wr_in && (reg_addr_in == `ADDR_HI_BASE);
    wire       wr_ctl_lo = reg_wr_in && (reg_addr_in == `ADDR_LO_BASE);

    assign fifo_push   = msg_valid_in && msg_ready_out;
    assign drain_valid = (fifo_count != 2'h0);
    // Commit takes two cycles per message so the buffer can really fill
    assign drain_ready = ~commit_hold;
    assign fifo_pop    = drain_valid && drain_ready;

    // Assembly buffer handed off as soon as a slot is free
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr        <= 1'b0;
            rd_ptr        <= 1'b0;
            fifo_count    <= 2'h0;
            msg_ready_out <= 1'b1;
            commit_hold   <= 1'b0;
        end else begin
            if (fifo_push) begin
                fifo_mem[wr_ptr] <= {msg_data_in, msg_error_in,
                                     lo_filter_hit_in, hi_filter_hit_in};
                wr_ptr <= ~wr_ptr;
            end
            if (fifo_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            commit_hold <= fifo_pop;
            case ({fifo_push, fifo_pop})
                2'b10: begin
                    fifo_count    <= fifo_count + 2'h1;
                    msg_ready_out <= (fifo_count == 2'h0);
                end
                2'b01: begin
                    fifo_count    <= fifo_count - 2'h1;
                    msg_ready_out <= 1'b1;
                end
                default: begin
                    fifo_count    <= fifo_count;
                    msg_ready_out <= msg_ready_out;
                end
            endcase
        end
    end

    // Acceptance and target selection
    always @* begin
        head     = fifo_mem[rd_ptr];
        head_msg = head[ENT_W-1:NF+1];
        head_err = head[NF];
        head_hit = head[NF-1:0];
        mode_hi  = high_priority_buffer_control[`CTL_MODE_HI:`CTL_MODE_LO];
        mode_lo  = low_priority_buffer_control[`CTL_MODE_HI:`CTL_MODE_LO];
        // A filter only matches frames of its own identifier type
        for (i = 0; i < NF; i = i + 1) begin
            hit_eff[i] = head_hit[i] &&
                         (extended_id_select_in[i] == head_msg[`MSG_EXT]);
        end
        hit_num_hi = 3'h0;
        for (i = HI_FILTERS - 1; i >= 0; i = i - 1) begin
            if (hit_eff[i]) begin
                hit_num_hi = i[2:0];
            end
        end
        hit_num_lo = HI_FILTERS[2:0];
        for (i = NF - 1; i >= HI_FILTERS; i = i - 1) begin
            if (hit_eff[i]) begin
                hit_num_lo = i[2:0];
            end
        end
        // Reserved modes behave as the filtered mode; software avoids them
        if (mode_hi == `MODE_ANY) begin
            accept_hi = 1'b1;
        end else begin
            accept_hi = ~head_err && (|hit_eff[HI_FILTERS-1:0]);
        end
        if (mode_lo == `MODE_ANY) begin
            accept_lo = 1'b1;
        end else begin
            accept_lo = ~head_err && (|hit_eff[NF-1:HI_FILTERS]);
        end
        load_hi     = 1'b0;
        load_lo     = 1'b0;
        discard_hi  = 1'b0;
        discard_lo  = 1'b0;
        load_lo_hit = hit_num_lo;
        if (fifo_pop) begin
            // High-priority buffer is considered first
            if (accept_hi) begin
                if (!rx_full_flag[0]) begin
                    load_hi = 1'b1;
                end else if (high_priority_buffer_control[`CTL_ROLL]) begin
                    // Rollover ignores the low buffer's own filters
                    load_lo_hit = hit_num_hi;
                    if (!rx_full_flag[1]) begin
                        load_lo = 1'b1;
                    end else begin
                        discard_lo = 1'b1;
                    end
                end else begin
                    discard_hi = 1'b1;
                end
            end else if (accept_lo) begin
                if (!rx_full_flag[1]) begin
                    load_lo = 1'b1;
                end else begin
                    discard_lo = 1'b1;
                end
            end
        end
    end

    // Receive buffers, control registers and flags
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            high_priority_rx_buffer      <= {`MSG_W{1'b0}};
            low_priority_rx_buffer       <= {`MSG_W{1'b0}};
            high_priority_buffer_control <= `RST_CTRL;
            low_priority_buffer_control  <= `RST_CTRL;
            rx_full_flag                 <= 2'h0;
            rx_interrupt_enable          <= 2'h0;
            overflow_flag                <= 2'h0;
            buffer_full_pin_control      <= `RST_PIN_CTRL;
        end else begin
            // Each buffer is written only by its own load, so one can be
            // read while the other fills
            if (load_hi) begin
                high_priority_rx_buffer <= head_msg;
                high_priority_buffer_control[`CTL_RTR] <= head_msg[`MSG_RTR];
                high_priority_buffer_control[0] <= hit_num_hi[0];
            end else if (wr_ctl_hi) begin
                high_priority_buffer_control <=
                    (high_priority_buffer_control & ~(reg_mask_in & `WMASK_CTRL_HI)) |
                    (wd_and_m & `WMASK_CTRL_HI);
            end
            if (load_lo) begin
                low_priority_rx_buffer <= head_msg;
                low_priority_buffer_control[`CTL_RTR] <= head_msg[`MSG_RTR];
                low_priority_buffer_control[2:0] <= load_lo_hit;
            end else if (wr_ctl_lo) begin
                low_priority_buffer_control <=
                    (low_priority_buffer_control & ~(reg_mask_in & `WMASK_CTRL_LO)) |
                    (wd_and_m & `WMASK_CTRL_LO);
            end
            // Copy of rollover enable for the read-only bit
            high_priority_buffer_control[`CTL_ROLL_COPY] <=
                high_priority_buffer_control[`CTL_ROLL];
            // A load in the clearing cycle keeps the flag set
            if (wr_if) begin
                rx_full_flag <= (rx_full_flag & keep_m[1:0]) | wd_and_m[1:0] |
                                {load_lo, load_hi};
            end else begin
                rx_full_flag <= rx_full_flag | {load_lo, load_hi};
            end
            if (wr_ef) begin
                overflow_flag <= (overflow_flag & keep_m[1:0]) | wd_and_m[1:0] |
                                 {discard_lo, discard_hi};
            end else begin
                overflow_flag <= overflow_flag | {discard_lo, discard_hi};
            end
            if (wr_ie) begin
                rx_interrupt_enable <= (rx_interrupt_enable & keep_m[1:0]) |
                                       wd_and_m[1:0];
            end
            // Masked write lets one pin level change alone
            if (wr_pin) begin
                buffer_full_pin_control <=
                    (buffer_full_pin_control & ~(reg_mask_in & `WMASK_PIN_CTRL)) |
                    (wd_and_m & `WMASK_PIN_CTRL);
            end
        end
    end

    // Interrupt and buffer-full pins, one cycle after the flag
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            int_n_out              <= 1'b1;
            buffer_full_pin_out    <= 2'h3;
            buffer_full_pin_oe_out <= 2'h0;
        end else begin
            int_n_out <= ~|(rx_full_flag & rx_interrupt_enable);
            for (j = 0; j < 2; j = j + 1) begin
                if (!buffer_full_pin_control[`PIN_EN_LO + j]) begin
                    buffer_full_pin_oe_out[j] <= 1'b0;
                    buffer_full_pin_out[j]    <= 1'b1;
                end else if (buffer_full_pin_control[`PIN_FN_LO + j]) begin
                    buffer_full_pin_oe_out[j] <= 1'b1;
                    buffer_full_pin_out[j]    <= ~rx_full_flag[j];
                end else begin
                    buffer_full_pin_oe_out[j] <= 1'b1;
                    buffer_full_pin_out[j]    <=
                        buffer_full_pin_control[`PIN_LEVEL_LO + j];
                end
            end
        end
    end

    // Start-of-frame: edge on idle bus must survive to the sample point
    always @* begin
        next_sof_state = sof_state;
        case (sof_state)
            `SOF_IDLE: begin
                if (sof_enable_in && bus_idle_in && bus_rx_prev &&
                    !bus_receive_input_in) begin
                    next_sof_state = `SOF_WAIT;
                end
            end
            `SOF_WAIT: begin
                if (bus_receive_input_in) begin
                    next_sof_state = `SOF_IDLE;
                end else if (sample_point_in) begin
                    next_sof_state = `SOF_HOLD;
                end
            end
            `SOF_HOLD: begin
                // Re-arm only once the frame has left the idle state
                if (!bus_idle_in) begin
                    next_sof_state = `SOF_IDLE;
                end
            end
            default: begin
                next_sof_state = `SOF_IDLE;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            sof_state        <= `SOF_IDLE;
            bus_rx_prev      <= 1'b1;
            sof_pulse_out    <= 1'b0;
            glitch_pulse_out <= 1'b0;
        end else begin
            sof_state        <= next_sof_state;
            bus_rx_prev      <= bus_receive_input_in;
            sof_pulse_out    <= (sof_state == `SOF_WAIT) && !bus_receive_input_in &&
                                sample_point_in;
            glitch_pulse_out <= (sof_state == `SOF_WAIT) &&
                                bus_receive_input_in;
        end
    end

    // Byte view of a stored message, index 1 to 13
    function [7:0] msg_byte;
        input [`MSG_W-1:0] m;
        input [3:0]        idx;
        begin
            case (idx)
                4'h1: msg_byte = m[`MSG_SID_HI:`MSG_SID_LO+3];
                4'h2: msg_byte = {m[`MSG_SID_LO+2:`MSG_SID_LO], 1'b0, m[`MSG_EXT],
                                  1'b0, m[`MSG_EID_HI:`MSG_EID_HI-1]};
                4'h3: msg_byte = m[`MSG_EID_LO+15:`MSG_EID_LO+8];
                4'h4: msg_byte = m[`MSG_EID_LO+7:`MSG_EID_LO];
                4'h5: msg_byte = {1'b0, m[`MSG_RTR], 2'h0, m[`MSG_DLC_HI:`MSG_DLC_LO]};
                4'h6: msg_byte = m[63:56];
                4'h7: msg_byte = m[55:48];
                4'h8: msg_byte = m[47:40];
                4'h9: msg_byte = m[39:32];
                4'hA: msg_byte = m[31:24];
                4'hB: msg_byte = m[23:16];
                4'hC: msg_byte = m[15:8];
                4'hD: msg_byte = m[7:0];
                default: msg_byte = 8'h00;
            endcase
        end
    endfunction

    // Register reads; unmapped addresses read zero
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == `ADDR_PIN_CTRL) begin
                reg_rdata_out <= buffer_full_pin_control;
            end else if (reg_addr_in == `ADDR_INT_EN) begin
                reg_rdata_out <= {6'h00, rx_interrupt_enable};
            end else if (reg_addr_in == `ADDR_INT_FLAG) begin
                reg_rdata_out <= {6'h00, rx_full_flag};
            end else if (reg_addr_in == `ADDR_ERR_FLAG) begin
                reg_rdata_out <= {6'h00, overflow_flag};
            end else if (reg_addr_in == `ADDR_HI_BASE) begin
                reg_rdata_out <= high_priority_buffer_control;
            end else if (reg_addr_in == `ADDR_LO_BASE) begin
                reg_rdata_out <= low_priority_buffer_control;
            end else if (reg_addr_in[7:4] == `ADDR_HI_BASE >> 4 &&
                         reg_addr_in[3:0] <= `BUF_BYTES) begin
                reg_rdata_out <= msg_byte(high_priority_rx_buffer, reg_addr_in[3:0]);
            end else if (reg_addr_in[7:4] == `ADDR_LO_BASE >> 4 &&
                         reg_addr_in[3:0] <= `BUF_BYTES) begin
                reg_rdata_out <= msg_byte(low_priority_rx_buffer, reg_addr_in[3:0]);
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

endmodule

// ### testbench/assembly_model.sv
// Purpose: Message source standing in for the protocol engine
// Assumes: send is called just after a rising edge
// Notes:   Released lines show inverted data
`timescale 1ns/100ps
module assembly_model (
    input  wire        clk_in,
    input  wire        ready_in,
    output reg         valid_out = 1'b0,
    output reg  [98:0] msg_out = 99'h0,
    output reg         error_out = 1'b0,
    output reg  [1:0]  hi_hit_out = 2'h0,
    output reg  [3:0]  lo_hit_out = 4'h0
);
    task send(input [98:0] m, input e, input [1:0] h, input [3:0] l);
        begin
            valid_out <= 1'b1;
            msg_out <= m;
            error_out <= e;
            hi_hit_out <= h;
            lo_hit_out <= l;
            @(posedge clk_in);
            while (!ready_in) @(posedge clk_in);
        end
    endtask
    task release_bus;
        begin
            valid_out <= 1'b0;
            msg_out <= ~msg_out;
            hi_hit_out <= ~hi_hit_out;
            lo_hit_out <= ~lo_hit_out;
        end
    endtask
endmodule

// ### testbench/can_rx_buffer_ctrl_bench.sv
// Purpose: Self-checking bench for the receive buffer control
// Assumes: Bit-modify register port, message source model
// Notes:   Loads are given five cycles to settle
`timescale 1ns/100ps
`include "can_rx_buffer_consts.vh"
module can_rx_buffer_ctrl_bench;
    reg         clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         rx = 1'b1;
    reg         idle = 1'b0;
    reg         spt = 1'b0;
    reg         sof_en = 1'b0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [7:0]  wdata = 8'h00;
    reg  [7:0]  mask = 8'h00;
    reg  [5:0]  xsel = 6'h00;
    wire        valid, ready, err, sof, glitch, int_n;
    wire [98:0] msg;
    wire [1:0]  hh, pin, oe;
    wire [3:0]  lh;
    wire [7:0]  rdata;
    integer     n_fail = 0;
    integer     n_checks = 0;
    integer     n_sof = 0;
    integer     n_glitch = 0;
    integer     n_stall = 0;
    integer     i;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (sof === 1'b1) n_sof <= n_sof + 1;
        if (glitch === 1'b1) n_glitch <= n_glitch + 1;
        if (valid && ready === 1'b0) n_stall <= n_stall + 1;
    end
    assembly_model assembly_model_i (.clk_in(clk_in), .ready_in(ready), .valid_out(valid),
        .msg_out(msg), .error_out(err), .hi_hit_out(hh), .lo_hit_out(lh));
    can_rx_buffer_ctrl can_rx_buffer_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .msg_valid_in(valid), .msg_ready_out(ready), .msg_data_in(msg), .msg_error_in(err),
        .hi_filter_hit_in(hh), .lo_filter_hit_in(lh), .extended_id_select_in(xsel),
        .bus_receive_input_in(rx), .bus_idle_in(idle), .sample_point_in(spt),
        .sof_enable_in(sof_en), .sof_pulse_out(sof), .glitch_pulse_out(glitch),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_mask_in(mask),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .int_n_out(int_n),
        .buffer_full_pin_out(pin), .buffer_full_pin_oe_out(oe));
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrm(input [7:0] a, input [7:0] d, input [7:0] m);
        begin
            addr <= a;
            wdata <= d;
            mask <= m;
            wr <= 1'b1;
            @(posedge clk_in);
            wr <= 1'b0;
            repeat (3) @(posedge clk_in);
            #1;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clk_in);
            rd <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask
    task snd(input [98:0] m, input e, input [1:0] h, input [3:0] l);
        begin
            assembly_model_i.send(m, e, h, l);
            assembly_model_i.release_bus();
            repeat (5) @(posedge clk_in);
            #1;
        end
    endtask
    function [98:0] mk(input [10:0] sid, input rtr, input [7:0] b);
        integer   k;
        reg [63:0] d;
        begin
            for (k = 0; k < 8; k = k + 1) d[63-8*k -: 8] = b + k[7:0];
            mk = {sid, 18'h0, 1'b0, rtr, 4'h8, d};
        end
    endfunction
    task finish_test;
        begin
            $display("checks %0d failures %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #400000;
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({6'h0, oe}, 8'h00);
        rdc(`ADDR_PIN_CTRL, `RST_PIN_CTRL);
        rdc(8'h50, 8'h00);
        rdc(`ADDR_HI_BASE, `RST_CTRL);
        wrm(`ADDR_INT_EN, 8'h03, 8'hFF);
        wrm(`ADDR_PIN_CTRL, 8'h0F, 8'h0F);
        snd(mk(11'h5A3, 1'b1, 8'h10), 1'b0, 2'b10, 4'h0);
        chk({5'h0, int_n, pin}, 8'h02);
        chk({6'h0, oe}, 8'h03);
        rdc(`ADDR_INT_FLAG, 8'h01);
        rdc(`ADDR_HI_BASE, 8'h09);
        rdc(`ADDR_HI_BASE + 8'h01, 8'hB4);
        for (i = 0; i < 8; i = i + 1) rdc(`ADDR_HI_BASE + 8'h06 + i[7:0], 8'h10 + i[7:0]);
        snd(mk(11'h111, 1'b0, 8'h40), 1'b0, 2'b01, 4'h0);
        rdc(`ADDR_HI_BASE + 8'h06, 8'h10);
        rdc(`ADDR_ERR_FLAG, 8'h01);
        snd(mk(11'h222, 1'b0, 8'h20), 1'b0, 2'b00, 4'b0100);
        rdc(`ADDR_INT_FLAG, 8'h03);
        rdc(`ADDR_LO_BASE, 8'h04);
        chk({5'h0, int_n, pin}, 8'h00);
        wrm(`ADDR_INT_FLAG, 8'h00, 8'h01);
        chk({5'h0, int_n, pin}, 8'h01);
        wrm(`ADDR_INT_FLAG, 8'h00, 8'h02);
        chk({5'h0, int_n, pin}, 8'h07);
        snd(mk(11'h333, 1'b0, 8'h30), 1'b0, 2'b01, 4'hF);
        rdc(`ADDR_INT_FLAG, 8'h01);
        rdc(`ADDR_HI_BASE, 8'h00);
        wrm(`ADDR_HI_BASE, 8'h04, 8'h04);
        snd(mk(11'h444, 1'b0, 8'h50), 1'b0, 2'b10, 4'h0);
        rdc(`ADDR_INT_FLAG, 8'h03);
        rdc(`ADDR_LO_BASE, 8'h01);
        rdc(`ADDR_LO_BASE + 8'h06, 8'h50);
        wrm(`ADDR_INT_FLAG, 8'h00, 8'h03);
        snd(mk(11'h666, 1'b0, 8'h60), 1'b1, 2'b01, 4'h0);
        snd(mk(11'h667, 1'b0, 8'h68), 1'b0, 2'b00, 4'h0);
        xsel <= 6'h01;
        snd(mk(11'h668, 1'b0, 8'h69), 1'b0, 2'b01, 4'h0);
        rdc(`ADDR_INT_FLAG, 8'h00);
        wrm(`ADDR_HI_BASE, 8'h60, 8'h60);
        snd(mk(11'h555, 1'b0, 8'h70), 1'b1, 2'b00, 4'h0);
        rdc(`ADDR_INT_FLAG, 8'h01);
        rdc(`ADDR_HI_BASE + 8'h06, 8'h70);
        wrm(`ADDR_PIN_CTRL, 8'h1C, 8'h3F);
        chk({4'h0, oe, pin}, 8'h0D);
        wrm(`ADDR_PIN_CTRL, 8'h20, 8'h30);
        chk({4'h0, oe, pin}, 8'h0E);
        wrm(`ADDR_PIN_CTRL, 8'h00, 8'h0C);
        chk({6'h0, oe}, 8'h00);
        for (i = 0; i < 4; i = i + 1)
            assembly_model_i.send(mk(11'h7F0, 1'b0, 8'h80), 1'b0, 2'b01, 4'h1);
        assembly_model_i.release_bus();
        repeat (10) @(posedge clk_in);
        chk({7'h0, n_stall > 0}, 8'h01);
        sof_en <= 1'b1;
        idle <= 1'b1;
        @(posedge clk_in);
        rx <= 1'b0;
        @(posedge clk_in);
        spt <= 1'b1;
        @(posedge clk_in);
        spt <= 1'b0;
        rx <= 1'b1;
        idle <= 1'b0;
        repeat (3) @(posedge clk_in);
        idle <= 1'b1;
        repeat (2) @(posedge clk_in);
        rx <= 1'b0;
        @(posedge clk_in);
        rx <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        chk(n_sof[7:0], 8'h01);
        chk(n_glitch[7:0], 8'h01);
        finish_test;
    end
endmodule

// ### testbench/can_rx_monitor.sv
// Purpose: Port checker for the receive buffer control
// Assumes: One clock, synchronous active-low reset
// Notes:   Registered outputs are allowed one or two edges
`timescale 1ns/100ps
module can_rx_monitor (
    input wire       clk_in,
    input wire       rst_n_in,
    input wire       msg_valid_in,
    input wire       msg_ready_out,
    input wire       bus_receive_input_in,
    input wire       bus_idle_in,
    input wire       sample_point_in,
    input wire       sof_enable_in,
    input wire       sof_pulse_out,
    input wire       glitch_pulse_out,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       int_n_out,
    input wire [1:0] buffer_full_pin_oe_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_fall;
        bus_idle_in && sof_enable_in && bus_receive_input_in
        ##1 bus_idle_in && sof_enable_in && !bus_receive_input_in;
    endsequence
    sequence s_held;
        s_fall ##1 (sample_point_in && !bus_receive_input_in);
    endsequence
    sequence s_short;
        s_fall ##1 (bus_receive_input_in && !sample_point_in);
    endsequence
    a_sof_at_sample: assert property (s_held |=> sof_pulse_out)
        else $error("no start pulse after held edge");
    a_glitch_no_sof: assert property (s_short |=> glitch_pulse_out && !sof_pulse_out)
        else $error("short dominant not flagged as glitch");
    a_sof_cause: assert property (sof_pulse_out |->
        $past(sample_point_in) && !$past(bus_receive_input_in))
        else $error("start pulse without sample point");
    a_glitch_cause: assert property (glitch_pulse_out |->
        $past(bus_receive_input_in) && !sof_pulse_out)
        else $error("glitch pulse without recessive return");
    a_oe_by_write: assert property (!$stable(buffer_full_pin_oe_out) |->
        $past(reg_wr_in) || $past(reg_wr_in, 2))
        else $error("pin enable moved without a write");
    a_int_release: assert property ($rose(int_n_out) |->
        $past(reg_wr_in) || $past(reg_wr_in, 2))
        else $error("interrupt released without host write");
    a_ready_cause: assert property ($fell(msg_ready_out) |-> $past(msg_valid_in))
        else $error("ready dropped without traffic");
    a_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("read data moved without a read");
endmodule
bind can_rx_buffer_ctrl can_rx_monitor can_rx_monitor_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .msg_valid_in(msg_valid_in),
    .msg_ready_out(msg_ready_out), .bus_receive_input_in(bus_receive_input_in),
    .bus_idle_in(bus_idle_in), .sample_point_in(sample_point_in),
    .sof_enable_in(sof_enable_in), .sof_pulse_out(sof_pulse_out),
    .glitch_pulse_out(glitch_pulse_out), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .int_n_out(int_n_out),
    .buffer_full_pin_oe_out(buffer_full_pin_oe_out));
